// >>> rtl/rcr_rail_control.sv
// i2c target and control registers of a multi-rail supply controller
// Summary of operation
// - write: start, address+write, sub-address, one data byte, stop
// - every eight-bit byte is followed by one acknowledge slot
// - receiver pulls data low in the acknowledge slot
// - no sub-address increment; only one data byte per write
// - read has no sub-address; returns level echo byte then status byte
// - offset 00h holds five rail enables at bits 7..3, reset 0
// - offset 01h holds lamp, disc, sound codes and system level bit
// - a rail's level code only takes effect while that rail is off
// - offset 02h holds ignition and supply-low threshold codes
// - bit 3 of 02h adds heat warning to the battery alarm
// - first read byte echoes the level codes, bit 0 reads zero
// - status bits 7..5: ignition low, supply low, supply high
// - status bit 4 supply cutoff, bit 3 heat warning
// - status bit 2 current limit, bits 1..0 read zero
// - power-up reset enters standby with every rail off
// - monitor reset holds the bus and register logic in reset and clears all registers
// - supply cutoff clears the rail enables until rewritten
// - current limit flag is the OR of switchable rail limits
// - alarm pin low on supply low/high, and heat when mode set
module rcr_rail_control #(
  parameter logic [6:0] DevAddr = rcr_pkg::RCR_DEV_ADDR
) (
  // system clock and power-up reset
  input  wire logic       clk,
  input  wire logic       rst,
  // supply monitor reset, active low, asynchronous to clk
  input  wire logic       resetOutN,
  // i2c link; scl is the link clock
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  // detector inputs, active high, asynchronous
  input  wire logic       ignitionLowIn,
  input  wire logic       supplyLowIn,
  input  wire logic       supplyHighIn,
  input  wire logic       supplyCutoffIn,
  input  wire logic       heatWarningIn,
  input  wire logic [4:0] railLimitIn,
  // rail enables
  output logic            lampRailOn,
  output logic            discRailOn,
  output logic            soundRailOn,
  output logic            systemRailOn,
  output logic            amplifierSwitchOn,
  // effective rail levels
  output logic [1:0]      lampRailLevel,
  output logic [1:0]      discRailLevel,
  output logic [1:0]      soundRailLevel,
  output logic            systemRailLevel,
  // detector thresholds and alarm pin
  output logic [1:0]      ignitionThreshold,
  output logic [1:0]      supplyLowThreshold,
  output logic            batteryAlarmPinN
);
  import rcr_pkg::*;

  // two clock domains: the scl side only captures the data wire and flips
  // a toggle on each rising scl edge; the clk side synchronises the toggle
  // and reads the captured bit once the toggle has crossed, by which time
  // the capture has been stable for at least two clk periods. start and
  // stop are found on the clk side from synchronised copies of both wires,
  // since they happen while scl stands high and give the scl side no edge.
  // link-side state, clocked by scl
  typedef struct packed {
    logic sdaCap;
    logic edgeTgl;
  } rcr_link_t;

  // system-side state, clocked by clk
  typedef struct packed {
    logic [1:0] sclS;
    logic [1:0] sdaS;
    logic       sclP;
    logic       sdaP;
    logic [2:0] tglS;
    logic [1:0] rstS;
    logic [9:0] flgA;
    logic [9:0] flgB;
    rcr_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] sub;
    logic       ack;
    logic       rdSecond;
    logic [7:0] tx;
    logic [7:0] enable;
    logic [7:0] level;
    logic [7:0] sensing;
    logic [6:0] effLevel;
    logic       sdaOeN;
    logic       alarmN;
  } rcr_sys_t;

  rcr_link_t lnk_q, lnk_d;
  rcr_sys_t  sys_q, sys_d;

  // link side: capture each bit on the rising scl edge, flag it by toggle
  always_comb begin
    lnk_d         = lnk_q;
    lnk_d.sdaCap  = sdaIn;
    lnk_d.edgeTgl = ~lnk_q.edgeTgl;
  end

  // scl may stop between frames; nothing here needs an edge after a stop.
  // the monitor reset does not reach this side: the toggle only marks
  // edges, so its level after a reset carries no meaning
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // live status byte from synchronised detector flags
  logic [7:0] statusByte;
  logic [7:0] echoByte;
  logic       startEv;
  logic       stopEv;
  logic       bitEv;
  logic       sclFall;
  logic       hold;

  // event decode reads only the second synchroniser stage onward
  // this relies on the host moving data at least two clk periods after
  // scl falls: the synchronised scl is then low before the data change
  // arrives, so no false start or stop is decoded inside a bit slot
  always_comb begin
    statusByte               = RCR_RST_STATUS;
    statusByte[RCR_ST_IGN]   = sys_q.flgB[0];
    statusByte[RCR_ST_LOW]   = sys_q.flgB[1];
    statusByte[RCR_ST_HIGH]  = sys_q.flgB[2];
    statusByte[RCR_ST_CUT]   = sys_q.flgB[3];
    statusByte[RCR_ST_HEAT]  = sys_q.flgB[4];
    // any switchable rail in limit; the logic supply rail has no input here
    statusByte[RCR_ST_LIMIT] = |sys_q.flgB[9:5];
    // the echo shows the stored codes, not the effective levels
    echoByte = {sys_q.level[7:1], 1'b0};
    startEv  = sys_q.sclP & sys_q.sclS[1] & sys_q.sdaP & ~sys_q.sdaS[1];
    stopEv   = sys_q.sclP & sys_q.sclS[1] & ~sys_q.sdaP & sys_q.sdaS[1];
    bitEv    = sys_q.tglS[2] ^ sys_q.tglS[1];
    sclFall  = sys_q.sclP & ~sys_q.sclS[1];
    hold     = ~sys_q.rstS[1];
  end

  // protocol engine, register file and outputs
  always_comb begin
    sys_d         = sys_q;
    // two-stage synchronisers; the first stage feeds only the second
    sys_d.sclS    = {sys_q.sclS[0], scl};
    sys_d.sdaS    = {sys_q.sdaS[0], sdaIn};
    sys_d.sclP    = sys_q.sclS[1];
    sys_d.sdaP    = sys_q.sdaS[1];
    // the toggle has a third stage so its edge can be found by comparison
    sys_d.tglS    = {sys_q.tglS[1:0], lnk_q.edgeTgl};
    sys_d.rstS    = {sys_q.rstS[0], resetOutN};
    // limit inputs are synchronised one by one and only then combined
    sys_d.flgA    = {railLimitIn, heatWarningIn, supplyCutoffIn,
                     supplyHighIn, supplyLowIn, ignitionLowIn};
    sys_d.flgB    = sys_q.flgA;

    // byte roles: ADDR takes the target address, SUB the register offset,
    // DATA the single write byte, READ sends the two read bytes and SKIP
    // refuses every further byte until the next start or stop
    if (stopEv) begin
      sys_d.st     = RCR_IDLE;
      sys_d.sdaOeN = 1'b1;
    end else if (startEv) begin
      // repeated start restarts the address phase as well
      sys_d.st       = RCR_ADDR;
      sys_d.bitCnt   = '0;
      sys_d.ack      = 1'b0;
      sys_d.rdSecond = 1'b0;
      sys_d.sdaOeN   = 1'b1;
    end else if (bitEv && sys_q.st != RCR_IDLE) begin
      if (sys_q.bitCnt != RCR_BITS_PER_BYTE) begin
        // data bit slot
        sys_d.shift  = {sys_q.shift[6:0], lnk_q.sdaCap};
        sys_d.tx     = {sys_q.tx[6:0], 1'b0};
        sys_d.bitCnt = sys_q.bitCnt + 4'h1;
        if (sys_q.bitCnt == RCR_BITS_PER_BYTE - 4'h1) begin
          // byte complete: decide the acknowledge for the next slot; the
          // write lands here, at the eighth data bit, before its ack slot
          unique case (sys_q.st)
            RCR_ADDR: begin
              sys_d.ack = (sys_d.shift[7:1] == DevAddr);
            end
            RCR_SUB: begin
              // kept even when it names no register; its data is dropped
              sys_d.sub = sys_d.shift;
              sys_d.ack = 1'b1;
            end
            RCR_DATA: begin
              sys_d.ack = 1'b1;
              unique case (sys_q.sub)
                RCR_OFS_ENABLE:  sys_d.enable  = sys_d.shift;
                RCR_OFS_LEVEL:   sys_d.level   = sys_d.shift;
                RCR_OFS_SENSING: sys_d.sensing = sys_d.shift;
                default: ;
              endcase
            end
            RCR_READ: sys_d.ack = 1'b0;
            RCR_SKIP: sys_d.ack = 1'b0;
            default:  sys_d.ack = 1'b0;
          endcase
        end
      end else begin
        // acknowledge slot just clocked: pick the next byte's role
        sys_d.bitCnt = '0;
        sys_d.ack    = 1'b0;
        unique case (sys_q.st)
          RCR_ADDR: begin
            if (!sys_q.ack) begin
              sys_d.st = RCR_IDLE;
            end else if (sys_q.shift[0]) begin
              sys_d.st = RCR_READ;
              sys_d.tx = echoByte;
            end else begin
              sys_d.st = RCR_SUB;
            end
          end
          RCR_SUB:  sys_d.st = RCR_DATA;
          RCR_DATA: sys_d.st = RCR_SKIP;
          RCR_READ: begin
            // host nack or second byte done ends the read
            if (lnk_q.sdaCap || sys_q.rdSecond) begin
              sys_d.st = RCR_SKIP;
            end else begin
              sys_d.rdSecond = 1'b1;
              // status taken live at the first byte's acknowledge
              sys_d.tx       = statusByte;
            end
          end
          RCR_SKIP: sys_d.st = RCR_SKIP;
          default:  sys_d.st = RCR_IDLE;
        endcase
      end
    end

    // pin drive changes only while scl is low
    // moving the drive a few clk after the fall keeps hold time on the wire;
    // the host must leave scl low for longer than three clk periods
    if (sclFall && !stopEv && !startEv) begin
      if (sys_q.bitCnt == RCR_BITS_PER_BYTE) begin
        sys_d.sdaOeN = ~sys_q.ack;
      end else if (sys_q.st == RCR_READ) begin
        sys_d.sdaOeN = sys_q.tx[7];
      end else begin
        sys_d.sdaOeN = 1'b1;
      end
    end

    // cutoff wins over a host write of the same cycle
    // applied on every cycle while the flag stands, so rails stay off until
    // the host writes the enables again after the cutoff has ended
    if (sys_q.flgB[3]) begin
      sys_d.enable = RCR_RST_ENABLE;
    end

    // level codes pass to the rails only while each rail is off
    // the level outputs lag a change of enable by one clk; a level written
    // while a rail is on is stored and takes effect once the rail is off
    if (!sys_q.enable[RCR_EN_LAMP]) begin
      sys_d.effLevel[6:5] = sys_q.level[RCR_LV_LAMP +: 2];
    end
    if (!sys_q.enable[RCR_EN_DISC]) begin
      sys_d.effLevel[4:3] = sys_q.level[RCR_LV_DISC +: 2];
    end
    if (!sys_q.enable[RCR_EN_SOUND]) begin
      sys_d.effLevel[2:1] = sys_q.level[RCR_LV_SOUND +: 2];
    end
    if (!sys_q.enable[RCR_EN_SYS]) begin
      sys_d.effLevel[0] = sys_q.level[RCR_LV_SYS];
    end

    // alarm pin is active low; heat counts only in the wider mode
    sys_d.alarmN = ~(sys_q.flgB[1] | sys_q.flgB[2] |
                     (sys_q.sensing[RCR_CF_ALARM] & sys_q.flgB[4]));

    // monitor reset returns the whole control state to standby
    // detector flags and the alarm pin keep working through it
    if (hold) begin
      sys_d.st       = RCR_IDLE;
      sys_d.bitCnt   = '0;
      sys_d.ack      = 1'b0;
      sys_d.rdSecond = 1'b0;
      sys_d.sdaOeN   = 1'b1;
      sys_d.enable   = RCR_RST_ENABLE;
      sys_d.level    = RCR_RST_LEVEL;
      sys_d.sensing  = RCR_RST_SENSING;
      sys_d.effLevel = '0;
      sys_d.shift    = '0;
      sys_d.sub      = '0;
      sys_d.tx       = '0;
    end
  end

  // power-up reset: standby, rails off, bus released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_q         <= '0;
      // sampled wires start at the idle high bus level: no false edge
      sys_q.sclS    <= 2'h3;
      sys_q.sdaS    <= 2'h3;
      sys_q.sclP    <= 1'b1;
      sys_q.sdaP    <= 1'b1;
      sys_q.st      <= RCR_IDLE;
      sys_q.enable  <= RCR_RST_ENABLE;
      sys_q.level   <= RCR_RST_LEVEL;
      sys_q.sensing <= RCR_RST_SENSING;
      sys_q.sdaOeN  <= 1'b1;
      sys_q.alarmN  <= 1'b1;
    end else begin
      sys_q <= sys_d;
    end
  end

  // outputs straight from flip-flops; the test bits 1:0 of sensing are
  // stored but steer nothing, host keeps them at zero
  // open drain: the value stays low and only the enable moves
  assign sdaOut             = 1'b0;
  assign sdaOeN             = sys_q.sdaOeN;
  assign lampRailOn         = sys_q.enable[RCR_EN_LAMP];
  assign discRailOn         = sys_q.enable[RCR_EN_DISC];
  assign soundRailOn        = sys_q.enable[RCR_EN_SOUND];
  assign systemRailOn       = sys_q.enable[RCR_EN_SYS];
  assign amplifierSwitchOn  = sys_q.enable[RCR_EN_AMP];
  assign lampRailLevel      = sys_q.effLevel[6:5];
  assign discRailLevel      = sys_q.effLevel[4:3];
  assign soundRailLevel     = sys_q.effLevel[2:1];
  assign systemRailLevel    = sys_q.effLevel[0];
  assign ignitionThreshold  = sys_q.sensing[RCR_CF_IGN +: 2];
  assign supplyLowThreshold = sys_q.sensing[RCR_CF_SLOW +: 2];
  assign batteryAlarmPinN   = sys_q.alarmN;
endmodule

// >>> rtl/rcr_pkg.sv
// constants and types shared by the rail control register block
package rcr_pkg;
  // target address and register offsets
  localparam logic [6:0] RCR_DEV_ADDR    = 7'h08;
  localparam logic [7:0] RCR_OFS_ENABLE  = 8'h00;
  localparam logic [7:0] RCR_OFS_LEVEL   = 8'h01;
  localparam logic [7:0] RCR_OFS_SENSING = 8'h02;
  // reset values
  localparam logic [7:0] RCR_RST_ENABLE  = 8'h00;
  localparam logic [7:0] RCR_RST_LEVEL   = 8'h00;
  localparam logic [7:0] RCR_RST_SENSING = 8'h00;
  localparam logic [7:0] RCR_RST_STATUS  = 8'h00;
  // rail_enable field positions
  localparam int RCR_EN_LAMP  = 7;
  localparam int RCR_EN_DISC  = 6;
  localparam int RCR_EN_SOUND = 5;
  localparam int RCR_EN_SYS   = 4;
  localparam int RCR_EN_AMP   = 3;
  // rail_level_select field positions (low bit of each field)
  localparam int RCR_LV_LAMP  = 6;
  localparam int RCR_LV_DISC  = 4;
  localparam int RCR_LV_SOUND = 2;
  localparam int RCR_LV_SYS   = 1;
  // sensing_config field positions
  localparam int RCR_CF_IGN   = 6;
  localparam int RCR_CF_SLOW  = 4;
  localparam int RCR_CF_ALARM = 3;
  // status_flags field positions
  localparam int RCR_ST_IGN   = 7;
  localparam int RCR_ST_LOW   = 6;
  localparam int RCR_ST_HIGH  = 5;
  localparam int RCR_ST_CUT   = 4;
  localparam int RCR_ST_HEAT  = 3;
  localparam int RCR_ST_LIMIT = 2;
  // bit slot counts: eight data bits, then the acknowledge slot
  localparam logic [3:0] RCR_BITS_PER_BYTE = 4'h8;
  // protocol states
  typedef enum logic [2:0] {
    RCR_IDLE  = 3'b000,
    RCR_ADDR  = 3'b001,
    RCR_SUB   = 3'b010,
    RCR_DATA  = 3'b011,
    RCR_READ  = 3'b100,
    RCR_SKIP  = 3'b101
  } rcr_state_t;
endpackage

// >>> bench/rcr_i2c_host.sv
// behavioural i2c bus controller standing in for the host
module rcr_i2c_host (
  // bus wires; sdaDrv high means released to the pull-up
  output logic scl,
  output logic sdaDrv,
  input  logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock stands still high between frames
  initial begin
    scl = 1'h1;
    sdaDrv = 1'h1;
  end
  // start or repeated start; the odd delay keeps scl off clk edges
  task automatic start();
    #23 sdaDrv = 1'h1;
    #20 scl = 1'h1;
    #20 sdaDrv = 1'h0;
    #20 scl = 1'h0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    #20 sdaDrv = 1'h0;
    #20 scl = 1'h1;
    #20 sdaDrv = 1'h1;
  endtask
  // one bit slot: data set mid-low, sampled mid-high
  task automatic slot(input logic b, output logic s);
    #20 sdaDrv = b;
    #20 scl = 1'h1;
    #20 s = sda;
    #20 scl = 1'h0;
  endtask
  // send a byte msb first, then listen in the acknowledge slot
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'h1, s);
    ack = !s;
  endtask
  // take a byte, acknowledging all but the last
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'h1, d[i]);
    slot(last, s);
  endtask
  // start, address, sub-address, one data byte, one extra byte if more, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d,
                    input logic more, output logic [3:0] ack);
    start();
    put({a, 1'h0}, ack[0]);
    put(r, ack[1]);
    put(d, ack[2]);
    ack[3] = 1'h0;
    if (more) put(8'hA5, ack[3]);
    stop();
  endtask
  // read: address with read bit, level echo then status, stop
  task automatic rd(input logic [6:0] a, output logic ack,
                    output logic [7:0] b1, b2);
    start();
    put({a, 1'h1}, ack);
    get(1'h0, b1);
    get(1'h1, b2);
    stop();
  endtask
endmodule

// >>> bench/rcr_rail_control_asserts.sv
// concurrent checks on the rail control register block ports
module rcr_rail_control_asserts (
  // clock, resets and link
  input logic       clk,
  input logic       rst,
  input logic       resetOutN,
  input logic       scl,
  input logic       sdaOeN,
  // detector levels
  input logic       supplyLowIn,
  input logic       supplyHighIn,
  input logic       supplyCutoffIn,
  input logic       heatWarningIn,
  // rail controls and alarm
  input logic       lampRailOn,
  input logic       discRailOn,
  input logic       soundRailOn,
  input logic       systemRailOn,
  input logic       amplifierSwitchOn,
  input logic [1:0] lampRailLevel,
  input logic [1:0] soundRailLevel,
  input logic [1:0] ignitionThreshold,
  input logic       batteryAlarmPinN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic anyOn;
  // any switchable rail still on
  assign anyOn = lampRailOn | discRailOn | soundRailOn | systemRailOn |
                 amplifierSwitchOn;
  // held long enough to pass the two-stage input sync
  sequence s_cut; supplyCutoffIn [*5]; endsequence
  sequence s_mon; !resetOutN [*5]; endsequence
  sequence s_bad; (supplyLowIn | supplyHighIn) [*6]; endsequence
  sequence s_calm;
    !(supplyLowIn | supplyHighIn | heatWarningIn) [*6];
  endsequence
  chk_cut_clears: assert property (
    @(posedge clk) disable iff (rst) s_cut |-> !anyOn)
    else $error("rail on during cutoff");
  chk_mon_clears: assert property (
    @(posedge clk) disable iff (rst) s_mon |-> !anyOn &&
      lampRailLevel == 2'h0 && ignitionThreshold == 2'h0)
    else $error("state kept in monitor reset");
  chk_alarm_low: assert property (
    @(posedge clk) disable iff (rst) s_bad |-> !batteryAlarmPinN)
    else $error("alarm not raised");
  chk_alarm_idle: assert property (
    @(posedge clk) disable iff (rst) s_calm |-> batteryAlarmPinN)
    else $error("alarm without cause");
  chk_lamp_frozen: assert property (
    @(posedge clk) disable iff (rst)
      lampRailOn && $past(lampRailOn) |-> $stable(lampRailLevel))
    else $error("lamp level moved while on");
  chk_sound_frozen: assert property (
    @(posedge clk) disable iff (rst)
      soundRailOn && $past(soundRailOn) |-> $stable(soundRailLevel))
    else $error("sound level moved while on");
  chk_drive_low: assert property (
    @(posedge clk) disable iff (rst) $fell(sdaOeN) |-> !scl)
    else $error("data pulled while clock high");
  chk_standby_off: assert property (
    @(posedge clk) disable iff (rst) $fell(rst) |-> !anyOn && sdaOeN)
    else $error("not in standby after reset");
endmodule
// checker attached to every instance of the block
bind rcr_rail_control rcr_rail_control_asserts chk_u (
  .clk, .rst, .resetOutN, .scl, .sdaOeN, .supplyLowIn, .supplyHighIn,
  .supplyCutoffIn, .heatWarningIn, .lampRailOn, .discRailOn, .soundRailOn,
  .systemRailOn, .amplifierSwitchOn, .lampRailLevel, .soundRailLevel,
  .ignitionThreshold, .batteryAlarmPinN);

// >>> bench/rcr_rail_control_tb.sv
// self-checking bench for the rail control register block
`define CHK(nm, e, a) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH %s exp %0h seen %0h", nm, e, a); \
  end \
end
module rcr_rail_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rcr_pkg::*;
  // design inputs, all valued at time zero
  logic       clk = 1'h0;
  logic       rst = 1'h0;
  logic       resetOutN = 1'h1;
  logic       ignitionLowIn = 1'h0;
  logic       supplyLowIn = 1'h0;
  logic       supplyHighIn = 1'h0;
  logic       supplyCutoffIn = 1'h0;
  logic       heatWarningIn = 1'h0;
  logic [4:0] railLimitIn = 5'h00;
  logic       scl, sdaIn, hostDrv;
  // design outputs
  logic       sdaOut, sdaOeN, lampRailOn, discRailOn, soundRailOn;
  logic       systemRailOn, amplifierSwitchOn, systemRailLevel;
  logic       batteryAlarmPinN;
  logic [1:0] lampRailLevel, discRailLevel, soundRailLevel;
  logic [1:0] ignitionThreshold, supplyLowThreshold;
  // model and bookkeeping
  int         mdl[3] = '{0, 0, 0};
  int         eff = 0;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         seed = 32'h24573918;
  logic [3:0] ack;
  logic [7:0] b1, b2, dat;
  // grouped outputs for comparison
  wire  [4:0] railsOn = {lampRailOn, discRailOn, soundRailOn, systemRailOn,
                         amplifierSwitchOn};
  wire  [6:0] levels = {lampRailLevel, discRailLevel, soundRailLevel,
                        systemRailLevel};
  wire  [3:0] thr = {ignitionThreshold, supplyLowThreshold};
  // 125 MHz clock; data wire pulled up unless the host or the device pulls low
  always #4 clk = ~clk;
  assign sdaIn = hostDrv & (sdaOeN | sdaOut);
  // device under test with its default target address
  rcr_rail_control dut_u (
    .clk, .rst, .resetOutN, .scl, .sdaIn, .sdaOut, .sdaOeN, .ignitionLowIn,
    .supplyLowIn, .supplyHighIn, .supplyCutoffIn, .heatWarningIn,
    .railLimitIn, .lampRailOn, .discRailOn, .soundRailOn, .systemRailOn,
    .amplifierSwitchOn, .lampRailLevel, .discRailLevel, .soundRailLevel,
    .systemRailLevel, .ignitionThreshold, .supplyLowThreshold,
    .batteryAlarmPinN);
  rcr_i2c_host host_u (.scl, .sdaDrv(hostDrv), .sda(sdaIn));
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one write; model keeps mapped registers, cutoff clear, frozen levels
  task automatic wr(input int r, input logic [7:0] d, input logic more);
    host_u.wr(RCR_DEV_ADDR, r[7:0], d, more, ack);
    `CHK("write ack", 4'h7, ack)
    if (r < 3) mdl[r] = d;
    if (supplyCutoffIn) mdl[0] = 0;
    for (int i = 0; i < 4; i++)
      if (!mdl[0][7 - i]) eff[7 - 2 * i -: 2] = mdl[1][7 - 2 * i -: 2];
    repeat (8) @(negedge clk);
  endtask
  // rails, levels, thresholds and alarm against the model
  task automatic outs();
    logic a;
    a = !(supplyLowIn | supplyHighIn | (heatWarningIn & mdl[2][3]));
    `CHK("enables", mdl[0][7:3], railsOn)
    `CHK("levels", eff[7:1], levels)
    `CHK("thresholds", mdl[2][7:4], thr)
    `CHK("alarm", a, batteryAlarmPinN)
  endtask
  // read both bytes; status expected live from the detector drive
  task automatic rd();
    logic [7:0] st;
    st = {ignitionLowIn, supplyLowIn, supplyHighIn, supplyCutoffIn,
          heatWarningIn, |railLimitIn, 2'h0};
    host_u.rd(RCR_DEV_ADDR, ack[0], b1, b2);
    `CHK("read ack", 1'h1, ack[0])
    `CHK("level echo", mdl[1] & 8'hFE, b1)
    `CHK("status", st, b2)
    repeat (4) @(negedge clk);
  endtask
  // reset, random traffic, foreign address, monitor reset
  initial begin
    // raised just after time zero so the link side sees a reset edge
    #1 rst = 1'h1;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    repeat (6) @(negedge clk);
    outs();
    rd();
    for (int k = 0; k < 24; k++) begin
      {ignitionLowIn, supplyLowIn, supplyHighIn, heatWarningIn,
       railLimitIn} = 9'($random(seed));
      supplyCutoffIn = (k % 7 == 6);
      repeat (6) @(negedge clk);
      // test bits of sensing_config kept at zero
      dat = 8'($random(seed));
      if (k % 4 == 2) dat[1:0] = 2'h0;
      wr(k % 4, dat, k % 5 == 4);
      outs();
      rd();
    end
    host_u.wr(RCR_DEV_ADDR ^ 7'h01, 8'h00, 8'hFF, 1'h0, ack);
    `CHK("foreign ack", 4'h0, ack)
    repeat (8) @(negedge clk);
    outs();
    wr(0, 8'hF8, 1'h0);
    outs();
    resetOutN = 1'h0;
    repeat (6) @(negedge clk);
    mdl = '{0, 0, 0};
    eff = 0;
    outs();
    resetOutN = 1'h1;
    repeat (6) @(negedge clk);
    rd();
    final_report();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule
